// ===== pkg/sef_pkg.sv
/*
 Constants for the serial port block: register offsets, field positions,
 reset values and the transfer state type.
 Assumes a 32-bit Avalon-MM bus with byte addresses.
*/
`default_nettype none
package sef_pkg;
	// Register byte offsets
	localparam logic [3:0] SEF_OFS_DATA  = 4'h0;
	localparam logic [3:0] SEF_OFS_CTRL  = 4'h4;
	localparam logic [3:0] SEF_OFS_STAT  = 4'h8;
	// Control register field positions
	localparam int SEF_C_IRQ_EN = 7;
	localparam int SEF_C_PORT_EN = 6;
	localparam int SEF_C_DIV_BYP = 5;
	localparam int SEF_C_CTRLR = 4;
	localparam int SEF_C_IDLE = 3;
	localparam int SEF_C_PHASE = 2;
	localparam int SEF_C_RATE = 0;
	// Status register field positions
	localparam int SEF_S_DONE = 7;
	localparam int SEF_S_WRITE_COLLISION_FLAG = 6;
	localparam int SEF_S_OVR = 5;
	localparam int SEF_S_FAULT = 4;
	localparam int SEF_S_OUT_DIS = 2;
	localparam int SEF_S_SW_SEL = 1;
	localparam int SEF_S_INT_SEL = 0;
	// Reset values
	localparam logic [7:0] SEF_CTRL_RST = 8'h00;
	localparam logic [2:0] SEF_STAT_RST = 3'h0;
	// Half-bit base count in system clocks, before rate scaling
	localparam logic [7:0] SEF_HALF_BASE = 8'h01;
	// Index of last edge in a byte (two edges per bit)
	localparam logic [3:0] SEF_LAST_EDGE = 4'hf;
	// Master transfer states
	typedef enum logic [0:0] {
		SEF_IDLE,
		SEF_RUN
	} sef_state_type;
endpackage
`default_nettype wire

// ===== core/sef_core.sv
/*
 Serial port with control register, error flags and one byte shifter.
 Assumes an Avalon-MM master on sys_clk; pins are split into in, out and
 active-low output enable, resolved outside.
*/
// How it works
// - Master sees select low: mode fault
// - Fault sets flag, irq when enabled
// - Fault clears port enable
// - Fault clears controller select
// - Fault clears: status read, control write
// - Fault blocks setting enable and controller
// - Byte done while done flag set: overrun
// - Overrun sets flag, irq when enabled
// - Overrun keeps first byte, drops later
// - Status read clears overrun flag
// - Data write mid transfer is discarded
// - Collision flag set, master or slave
// - Collision flag never requests irq
// - Receive buffer read synchronously
// - Bit 7 gates the interrupt request
// - Bit 6 enables port, reset clears
// - Bit 5 bypasses extra divide-by-two
// - Bit 4 selects controller, swaps pins
// - Bit 3 sets clock idle level
// - Control upper nibble zero at reset
// - Done flag: set, two-step clear, blocks
// - Software select overrides select pin
`timescale 1ns/1ns
`default_nettype none
module sef_core #(
	parameter int ADDR_W = 4
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	// Avalon-MM slave
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	// Interrupt request
	output logic             serial_irq,
	// Serial clock pin
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe_n,
	// Controller-out data pin
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe_n,
	// Controller-in data pin
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe_n,
	// Select pin
	input  wire logic        ss_n_in
);
	import sef_pkg::*;

	if (ADDR_W < 4) begin : g_chk
		$error("ADDR_W must be at least 4");
	end

	// Pin synchronisers, three flops per pin
	logic [2:0] sy1_q, sy2_q, sy3_q;
	logic [2:0] pin_q;            // Filtered sck, data-in, select
	wire  [2:0] pin_raw;
	// Control and status state
	logic [7:0] ctrl_q;           // serial_control_reg
	logic [2:0] sctl_q;           // Writable status bits
	logic       done_q;           // transfer_done_flag
	logic       write_collision_flag_q;           // write_collision_flag
	logic       ovr_q;            // receive_overrun_flag
	logic       fault_q;          // master_fault_flag
	logic       done_arm_q;       // Status read seen with done or write_collision_flag set
	logic       fault_arm_q;      // Status read seen with fault set
	logic [7:0] rx_buf_q;         // Receive buffer
	logic       ack_q;            // Bus answer cycle
	logic [31:0] rdata_q;         // Registered read data
	// Shifter state
	sef_state_type st_q;          // Controller transfer state
	logic [7:0] tx_q, rx_q;       // Shift registers
	logic [3:0] edge_q;           // Edge index within byte
	logic [7:0] div_q;            // Half-bit counter
	logic       sck_q;            // Driven clock level
	logic       sck_prev_q;       // Previous filtered clock

	// Field aliases
	wire irq_en    = ctrl_q[SEF_C_IRQ_EN];
	wire port_en   = ctrl_q[SEF_C_PORT_EN];
	wire ctrlr     = ctrl_q[SEF_C_CTRLR];
	wire idle_lvl  = ctrl_q[SEF_C_IDLE];
	wire phase     = ctrl_q[SEF_C_PHASE];
	wire div_byp   = ctrl_q[SEF_C_DIV_BYP];
	wire [1:0] rate = ctrl_q[SEF_C_RATE +: 2];

	// Synchroniser input vector
	assign pin_raw = {ss_n_in, (ctrlr ? miso_in : mosi_in), sck_in};

	// Three-flop sync; filtered value moves when stages two and three agree
	always_ff @(posedge sys_clk) begin
		sy1_q <= pin_raw;
		sy2_q <= sy1_q;
		sy3_q <= sy2_q;
	end
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pin_q <= 3'h7;
		end else begin
			pin_q <= (sy2_q & sy3_q) | (pin_q & (sy2_q ^ sy3_q)) | (sy2_q & ~sy3_q & pin_q);
		end
	end

	// Effective select level, software or pin
	wire sel_n = sctl_q[SEF_S_SW_SEL] ? sctl_q[SEF_S_INT_SEL] : pin_q[2];
	wire din   = pin_q[1];

	// Bus decode: request accepted at the answer edge
	wire req    = avs_read | avs_write;
	wire acc    = req & ack_q;
	wire hit_d  = avs_address[3:0] == SEF_OFS_DATA;
	wire hit_c  = avs_address[3:0] == SEF_OFS_CTRL;
	wire hit_s  = avs_address[3:0] == SEF_OFS_STAT;
	wire rd_s   = acc & avs_read & hit_s;
	wire wr_c   = acc & avs_write & hit_c;
	wire acc_d  = acc & hit_d;
	wire wr_d   = acc & avs_write & hit_d;
	wire [7:0] wbyte = avs_writedata[7:0];

	// One wait state: answer comes the cycle after the request rises
	assign avs_waitrequest = req & ~ack_q;
	assign avs_readdata    = rdata_q;

	// Status byte as software sees it
	wire [7:0] stat = {done_q, write_collision_flag_q, ovr_q, fault_q, 1'b0, sctl_q};

	// Read data mux, unmapped reads as zero
	wire [7:0] rmux = hit_d ? rx_buf_q : hit_c ? ctrl_q : hit_s ? stat : 8'h00;

	// Bus answer and read data
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q   <= req & ~ack_q;
			rdata_q <= {24'h00_0000, rmux};
		end
	end

	// Transfer in progress: controller run, or selected target with edge index nonzero
	wire tgt_busy = port_en & ~ctrlr & ~sel_n & (edge_q != 4'h0);
	wire busy     = (st_q == SEF_RUN) | tgt_busy;

	// Edge events
	wire half_end = div_q == 8'h00;
	wire c_edge   = (st_q == SEF_RUN) & half_end;
	wire t_edge   = port_en & ~ctrlr & ~sel_n & (pin_q[0] != sck_prev_q);
	wire s_edge   = c_edge | t_edge;
	// Sample on first edge of a bit for phase 0, second for phase 1
	wire samp     = s_edge & (edge_q[0] == phase);
	wire drive    = s_edge & (edge_q[0] != phase) & (edge_q != 4'h0);
	wire last     = s_edge & (edge_q == SEF_LAST_EDGE);
	wire [7:0] rx_next = {rx_q[6:0], din};
	wire [7:0] rx_byte = samp ? rx_next : rx_q;

	// Data write acceptance
	wire wr_block = done_q & ~done_arm_q;
	wire collide  = wr_d & busy;
	wire wr_ok    = wr_d & ~busy & ~wr_block;
	wire start    = wr_ok & port_en & ctrlr;

	// Mode fault detection while controller
	wire fault_ev = ctrlr & port_en & ~sel_n;

	// Fault-clearing control write may restore enable and controller
	wire fault_clr = wr_c & fault_arm_q;
	wire [7:0] wc = (fault_q & ~fault_clr) ?
		(wbyte & ~(8'h01 << SEF_C_PORT_EN) & ~(8'h01 << SEF_C_CTRLR)) : wbyte;

	// Control register, fault forces enable and controller low
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ctrl_q <= SEF_CTRL_RST;
		end else if (fault_ev) begin
			ctrl_q[SEF_C_PORT_EN] <= 1'b0;
			ctrl_q[SEF_C_CTRLR]   <= 1'b0;
		end else if (wr_c) begin
			ctrl_q <= wc;
		end
	end

	// Writable status bits
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sctl_q <= SEF_STAT_RST;
		end else if (acc & avs_write & hit_s) begin
			sctl_q <= wbyte[2:0];
		end
	end

	// Fault flag: set wins over the clearing write
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			fault_q     <= 1'b0;
			fault_arm_q <= 1'b0;
		end else begin
			fault_q     <= fault_ev | (fault_q & ~fault_clr);
			fault_arm_q <= (rd_s & fault_q) | (fault_arm_q & ~wr_c & fault_q);
		end
	end

	// Done and collision: status read arms, data access clears
	wire done_clr = acc_d & done_arm_q;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			done_q     <= 1'b0;
			write_collision_flag_q     <= 1'b0;
			done_arm_q <= 1'b0;
		end else begin
			done_q     <= (last & ~done_q) | (done_q & ~done_clr) | (last & done_q);
			write_collision_flag_q     <= collide | (write_collision_flag_q & ~done_clr);
			done_arm_q <= (rd_s & (done_q | write_collision_flag_q)) | (done_arm_q & ~acc_d);
		end
	end

	// Overrun: byte done while done flag still set; set wins over read
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			ovr_q <= 1'b0;
		end else begin
			ovr_q <= (last & done_q) | (ovr_q & ~rd_s);
		end
	end

	// Receive buffer keeps first byte since done was cleared
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rx_buf_q <= 8'h00;
		end else if (last & ~done_q) begin
			rx_buf_q <= rx_byte;
		end
	end

	// Interrupt: collision is deliberately not a source
	assign serial_irq = irq_en & (done_q | fault_q | ovr_q);

	// Controller state and half-bit timing
	wire [7:0] half_cnt = (SEF_HALF_BASE << rate) << !div_byp;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_q <= SEF_IDLE;
			div_q <= 8'h00;
		end else begin
			unique case (st_q)
				SEF_IDLE: begin
					div_q <= half_cnt - 8'h01;
					if (start) begin
						st_q <= SEF_RUN;
					end
				end
				SEF_RUN: begin
					div_q <= half_end ? half_cnt - 8'h01 : div_q - 8'h01;
					if (last | fault_ev) begin
						st_q <= SEF_IDLE;
					end
				end
			endcase
		end
	end

	// Edge index, idle level and shifters (eight bits MSB first)
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			edge_q     <= 4'h0;
			sck_q      <= 1'b0;
			sck_prev_q <= 1'b0;
			tx_q       <= 8'h00;
			rx_q       <= 8'h00;
		end else begin
			sck_prev_q <= pin_q[0];
			if (st_q == SEF_IDLE) begin
				sck_q <= idle_lvl;
			end else if (c_edge) begin
				sck_q <= ~sck_q;
			end
			if (wr_ok) begin
				tx_q <= wbyte;
			end else if (drive) begin
				tx_q <= {tx_q[6:0], 1'b0};
			end
			if (samp) begin
				rx_q <= rx_next;
			end
			if ((st_q == SEF_IDLE & (ctrlr | sel_n)) | fault_ev | ~port_en) begin
				edge_q <= 4'h0;
			end else if (s_edge) begin
				edge_q <= edge_q + 4'h1;
			end
		end
	end

	// Pins: free while disabled; controller drives clock and MOSI
	wire out_en = port_en & ~sctl_q[SEF_S_OUT_DIS];
	assign sck_out   = sck_q;
	assign sck_oe_n  = ~(port_en & ctrlr);
	assign mosi_out  = tx_q[7];
	assign mosi_oe_n = ~(out_en & ctrlr);
	assign miso_out  = tx_q[7];
	assign miso_oe_n = ~(out_en & ~ctrlr & ~sel_n);

	// Checks
	fault_ctrl_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		fault_ev |=> fault_q && !port_en && !ctrlr)
		else $error("fault did not drop enable and controller");
	fault_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		fault_q && !fault_arm_q ##1 fault_q && !fault_ev |-> !(port_en || ctrlr))
		else $error("enable set while fault pending");
	fault_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$fell(fault_q) |-> $past(wr_c) && $past(fault_arm_q))
		else $error("fault cleared without sequence");
	irq_src_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		serial_irq == (irq_en && (done_q || ovr_q || fault_q)))
		else $error("interrupt mismatch");
	write_collision_flag_noirq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		write_collision_flag_q && !done_q && !ovr_q && !fault_q |-> !serial_irq)
		else $error("collision raised interrupt");
	ovr_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		done_q && last |=> ovr_q && $stable(rx_buf_q))
		else $error("overrun lost kept byte");
	ovr_clear_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		rd_s && !(last && done_q) |=> !ovr_q)
		else $error("overrun not cleared by status read");
	write_collision_flag_drop_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		collide |=> write_collision_flag_q)
		else $error("collision flag not set");
	write_collision_flag_keep_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		collide && !drive |=> $stable(tx_q))
		else $error("colliding write reached shifter");
	wait_one_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read answer not in one cycle");
	idle_clk_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		st_q == SEF_IDLE ##1 st_q == SEF_IDLE |-> sck_out == $past(idle_lvl))
		else $error("clock not at idle level");
	cv_xfer: cover property (@(posedge sys_clk) disable iff (!nrst) last && ctrlr);
	cv_ovr: cover property (@(posedge sys_clk) disable iff (!nrst) $rose(ovr_q));
	cv_fault: cover property (@(posedge sys_clk) disable iff (!nrst) fault_clr);
	cv_write_collision_flag: cover property (@(posedge sys_clk) disable iff (!nrst) collide);
endmodule
`default_nettype wire

// ===== bench/sef_far_peer.sv
/*
 Far-side serial target used while the block is the controller.
 Assumes clock idle low, sampling on the leading edge.
*/
`timescale 1ns/1ns
`default_nettype none
module sef_far_peer (
	// Clocks and lines
	input  wire logic       clk,
	input  wire logic       sck,
	input  wire logic       mosi,
	output logic            miso,
	// Bench control
	input  wire logic       sel,
	input  wire logic       load,
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte
);
	logic [7:0] sh_q;	// Outgoing bits
	logic       tog_q;	// Junk level while released
	initial begin
		sh_q = 8'h00;
		rx_byte = 8'h00;
		tog_q = 1'b0;
	end
	// Released line wanders, never holds the last bit
	always @(posedge clk) tog_q <= ~tog_q;
	assign miso = sel ? sh_q[7] : tog_q;
	// Preload the next reply
	always @(posedge load) sh_q <= tx_byte;
	// Capture on leading edge, MSB first
	always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
	// Advance on trailing edge
	always @(negedge sck) sh_q <= {sh_q[6:0], 1'b0};
endmodule
`default_nettype wire

// ===== bench/test_sef_core.sv
/*
 Self-checking bench for the serial port block.
 Assumes Avalon-MM with one wait state and pins resolved here.
*/
`timescale 1ns/1ns
`default_nettype none
module test_sef_core;
	import sef_pkg::*;
	// Bench signals
	logic        sys_clk, nrst;
	logic [3:0]  avs_address;
	logic        avs_read, avs_write, avs_waitrequest, serial_irq;
	logic [31:0] avs_writedata, avs_readdata;
	logic        sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n;
	logic        b_sck, b_mosi, ss_n, p_miso, p_load;
	logic [7:0]  p_tx, p_rx, rd;
	int          num_errors, n_tests;
	// Resolved pin levels
	wire sck_l  = sck_oe_n ? b_sck : sck_out;
	wire mosi_l = mosi_oe_n ? b_mosi : mosi_out;
	wire miso_l = miso_oe_n ? p_miso : miso_out;
	sef_core u_sef_core (.sys_clk(sys_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .serial_irq(serial_irq), .sck_in(sck_l), .sck_out(sck_out),
		.sck_oe_n(sck_oe_n), .mosi_in(mosi_l), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
		.miso_in(miso_l), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n));
	sef_far_peer u_sef_far_peer (.clk(sys_clk), .sck(sck_l), .mosi(mosi_l), .miso(p_miso), .sel(ss_n),
		.load(p_load), .tx_byte(p_tx), .rx_byte(p_rx));
	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// Compare and count
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// One bus cycle; request held until waitrequest is seen low at a rising edge
	task bus(input logic wr, input logic [3:0] a, input logic [7:0] wd);
		@(posedge sys_clk);
		avs_address <= a;
		avs_read <= !wr;
		avs_write <= wr;
		avs_writedata <= {24'h0, wd};
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	// Bench as controller, mode 0, MSB first
	task send(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			b_mosi <= b[i];
			repeat (8) @(posedge sys_clk);
			b_sck <= 1'b1;
			repeat (8) @(posedge sys_clk);
			b_sck <= 1'b0;
		end
		repeat (10) @(posedge sys_clk);
	endtask
	// Reset values and unmapped place
	task t_reset;
		bus(0, SEF_OFS_CTRL, 8'h00); chk("ctrl", SEF_CTRL_RST, rd);
		bus(1, 4'hc, 8'hff);
		bus(0, 4'hc, 8'h00); chk("unmapped", 8'h00, rd);
		bus(0, SEF_OFS_STAT, 8'h00); chk("stat", 8'h00, rd);
		chk("irq", 8'h00, {7'h0, serial_irq});
	endtask
	// Idle level follows bit 3, port off between
	task t_idle;
		bus(1, SEF_OFS_CTRL, 8'h58);
		repeat (4) @(posedge sys_clk);
		chk("sck idle hi", 8'h01, {7'h0, sck_l});
		bus(1, SEF_OFS_CTRL, 8'h00);
		bus(1, SEF_OFS_CTRL, 8'h50);
		repeat (4) @(posedge sys_clk);
		chk("sck idle lo", 8'h00, {7'h0, sck_l});
		chk("sck oe_n", 8'h00, {7'h0, sck_oe_n});
		bus(1, SEF_OFS_CTRL, 8'h00);
	endtask
	// Controller byte with a colliding write
	task t_master;
		int n;
		n = 0;
		p_tx <= 8'h3c;
		p_load <= 1'b1;
		bus(1, SEF_OFS_CTRL, 8'hd3);
		p_load <= 1'b0;
		bus(1, SEF_OFS_DATA, 8'ha5);
		bus(1, SEF_OFS_DATA, 8'h5a);
		chk("irq busy", 8'h00, {7'h0, serial_irq});
		rd = 8'h00;
		while (rd[SEF_S_DONE] !== 1'b1 && n < 400) begin
			bus(0, SEF_OFS_STAT, 8'h00);
			n++;
		end
		chk("stat done", 8'hc0, rd);
		chk("irq done", 8'h01, {7'h0, serial_irq});
		bus(0, SEF_OFS_DATA, 8'h00); chk("rx", 8'h3c, rd);
		chk("peer rx", 8'ha5, p_rx);
		bus(0, SEF_OFS_STAT, 8'h00); chk("stat clr", 8'h00, rd);
		chk("irq clr", 8'h00, {7'h0, serial_irq});
		bus(1, SEF_OFS_CTRL, 8'h00);
	endtask
	// Target overrun
	task t_overrun;
		bus(1, SEF_OFS_CTRL, 8'hc0);
		ss_n <= 1'b0;
		send(8'h11);
		send(8'h22);
		bus(0, SEF_OFS_STAT, 8'h00); chk("stat ovr", 8'ha0, rd);
		chk("irq ovr", 8'h01, {7'h0, serial_irq});
		bus(0, SEF_OFS_DATA, 8'h00); chk("kept", 8'h11, rd);
		bus(0, SEF_OFS_STAT, 8'h00); chk("ovr clr", 8'h00, rd);
		ss_n <= 1'b1;
		bus(1, SEF_OFS_CTRL, 8'h00);
	endtask
	// Mode fault and its clearing sequence
	task t_fault;
		bus(1, SEF_OFS_CTRL, 8'h50);
		ss_n <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk("irq off", 8'h00, {7'h0, serial_irq});
		bus(0, SEF_OFS_CTRL, 8'h00); chk("ctrl fault", 8'h00, rd);
		bus(1, SEF_OFS_CTRL, 8'h50);
		bus(0, SEF_OFS_CTRL, 8'h00); chk("ctrl blocked", 8'h00, rd);
		ss_n <= 1'b1;
		bus(0, SEF_OFS_STAT, 8'h00); chk("stat fault", 8'h10, rd);
		bus(1, SEF_OFS_CTRL, 8'h50);
		bus(0, SEF_OFS_CTRL, 8'h00); chk("ctrl back", 8'h50, rd);
		bus(0, SEF_OFS_STAT, 8'h00); chk("fault clr", 8'h00, rd);
		// Software select: deselected despite low pin, then selected
		bus(1, SEF_OFS_CTRL, 8'h00);
		bus(1, SEF_OFS_STAT, 8'h03);
		ss_n <= 1'b0;
		repeat (6) @(posedge sys_clk);
		bus(1, SEF_OFS_CTRL, 8'hd0);
		repeat (6) @(posedge sys_clk);
		bus(0, SEF_OFS_STAT, 8'h00); chk("sw desel", 8'h03, rd);
		bus(1, SEF_OFS_STAT, 8'h02);
		repeat (2) @(posedge sys_clk);
		chk("irq fault", 8'h01, {7'h0, serial_irq});
		bus(0, SEF_OFS_STAT, 8'h00); chk("stat sw fault", 8'h12, rd);
		bus(1, SEF_OFS_STAT, 8'h00);
		ss_n <= 1'b1;
		bus(1, SEF_OFS_CTRL, 8'h00);
		bus(0, SEF_OFS_STAT, 8'h00); chk("sw fault clr", 8'h00, rd);
	endtask
	// Verdict
	task end_sim;
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#(40 * 20000);
		num_errors++;
		end_sim;
	end
	// Main sequence
	initial begin
		num_errors = 0;
		n_tests = 0;
		nrst = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		b_sck = 1'b0;
		b_mosi = 1'b0;
		ss_n = 1'b1;
		p_load = 1'b0;
		p_tx = 8'h00;
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset;
		t_idle;
		t_master;
		t_overrun;
		t_fault;
		end_sim;
	end
endmodule
`default_nettype wire
